// *** src/pll_cfg_pkg.sv ***
package pll_cfg_pkg;

    // ==========================================================
    // Register map and reset values
    // ==========================================================
    localparam logic [7:0]  ADDR_CFG_LO = 8'h00;
    localparam logic [7:0]  ADDR_CFG_HI = 8'h04;
    localparam logic [7:0]  ADDR_STATUS = 8'h08;
    localparam logic [63:0] CFG_RESET   = 64'h0000_0000_0000_0000;
    localparam logic [63:0] RSVD_MASK   = 64'h0000_0000_00C0_0000;

    // ==========================================================
    // Configuration field positions
    // ==========================================================
    localparam int REF_LSB     = 0;
    localparam int REF_W       = 12;
    localparam int DETECTOR_REF_SOURCE_BIT   = 14;
    localparam int POST_STAGE_ONE_SEL_LSB   = 16;
    localparam int POST_STAGE_TWO_SEL_LSB   = 18;
    localparam int POST_STAGE_THREE_SEL_LSB   = 20;
    localparam int FBK_LSB     = 24;
    localparam int FBK_W       = 14;
    localparam int FBSRC_LSB   = 38;
    localparam int OSC_SEL_LSB = 49;
    localparam int PUMP_LSB    = 52;
    localparam int POL_BIT     = 54;
    localparam int LOOP_PD_BIT = 55;
    localparam int CAP_LSB     = 56;
    localparam int FINE_BIT    = 61;
    localparam int CNT_W       = 14;
    localparam int PIN_REF     = 0;
    localparam int PIN_VCO     = 1;
    localparam int PIN_FBK     = 2;
    localparam int PIN_OSC     = 3;
    localparam int NPINS       = 4;
    localparam logic [2:0] OSC_PWRDN_CODE = 3'h7;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] ratio;
        logic             tick;
    } div_t;

    typedef struct packed {
        logic [63:0]      cfg;
        logic [NPINS-1:0] sync1;
        logic [NPINS-1:0] sync2;
        logic [NPINS-1:0] prev;
        div_t             ref_d;
        div_t             fbk_d;
        div_t             p1_d;
        div_t             p2_d;
        div_t             p3_d;
        div_t             osc_d;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic             pd_ref_tick;
        logic             fine_tune;
        logic             pol_inv;
        logic             loop_pd;
        logic             osc_pd;
        logic [3:0]       pump_sel;
        logic [3:0]       cap_code;
    } state_t;

    // ==========================================================
    // Ratio decoders
    // ==========================================================
    function automatic logic [CNT_W-1:0] post_bin_ratio(input logic [1:0] code);
        post_bin_ratio = CNT_W'(1) << code;
    endfunction

    function automatic logic [CNT_W-1:0] post_odd_ratio(input logic [1:0] code);
        case (code)
            2'h0:    post_odd_ratio = 14'h0001;
            2'h1:    post_odd_ratio = 14'h0003;
            2'h2:    post_odd_ratio = 14'h0005;
            default: post_odd_ratio = 14'h0004;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] osc_ratio(input logic [2:0] code);
        case (code)
            3'h0:    osc_ratio = 14'h0001;
            3'h1:    osc_ratio = 14'h0C00;
            3'h2:    osc_ratio = 14'h0C54;
            3'h3:    osc_ratio = 14'h097E;
            3'h4:    osc_ratio = 14'h09C4;
            3'h5:    osc_ratio = 14'h0FA0;
            3'h6:    osc_ratio = 14'h0D2F;
            default: osc_ratio = 14'h0000;
        endcase
    endfunction

endpackage

// *** src/pll_divider_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module pll_divider_config (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Clock pins, asynchronous to clk_in
    input  wire logic        ref_clk_in,
    input  wire logic        vco_clk_in,
    input  wire logic        fbk_pin_in,
    input  wire logic        osc_clk_in,
    // Divider strobes
    output logic             ref_div_tick_out,
    output logic             pd_ref_tick_out,
    output logic             post_tick_out,
    output logic             fbk_tick_out,
    output logic             osc_tick_out,
    // Crystal loop controls
    output logic             fine_tune_enable_out,
    output logic             tune_polarity_invert_out,
    output logic             osc_loop_powerdown_out,
    output logic             osc_powerdown_out,
    output logic      [3:0]  osc_loop_pump_current_out,
    output logic      [3:0]  coarse_cap_code_out
);

    // ==========================================================
    // Divider step
    // ==========================================================
    // The running ratio is replaced only at the wrap, so a period in progress is never cut short or stretched
    // by a new setting, except in the oscillator divider, whose ratio and count are reloaded while powered down.
    function automatic pll_cfg_pkg::div_t step(
        input pll_cfg_pkg::div_t                    d,
        input logic                                 ev,
        input logic [pll_cfg_pkg::CNT_W-1:0]        want
    );
        logic [pll_cfg_pkg::CNT_W:0] nxt;
        step      = d;
        step.tick = 1'b0;
        nxt       = {1'b0, d.cnt} + 15'h0001;
        if (ev) begin
            if (nxt >= {1'b0, d.ratio}) begin
                step.cnt   = '0;
                step.tick  = 1'b1;
                step.ratio = want;
            end else begin
                step.cnt = nxt[pll_cfg_pkg::CNT_W-1:0];
            end
        end
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    pll_cfg_pkg::state_t st;
    pll_cfg_pkg::state_t next_st;

    logic [pll_cfg_pkg::NPINS-1:0] edge_seen;
    logic [63:0]                   cfg_w;
    logic [1:0]                    fb_src;
    logic                          fb_ev;
    logic                          osc_off;
    logic [7:0]                    post_total;

    assign edge_seen = st.sync2 & ~st.prev;
    assign fb_src    = st.cfg[pll_cfg_pkg::FBSRC_LSB +: 2];
    assign osc_off   = st.cfg[pll_cfg_pkg::OSC_SEL_LSB +: 3] == pll_cfg_pkg::OSC_PWRDN_CODE
                       || st.cfg[pll_cfg_pkg::LOOP_PD_BIT];
    assign post_total = 8'(st.p1_d.ratio * st.p2_d.ratio * st.p3_d.ratio);

    always_comb begin
        next_st = st;
        cfg_w   = st.cfg;
        // Only the second stage feeds logic; the first is a pure synchroniser.
        next_st.sync1 = {osc_clk_in, fbk_pin_in, vco_clk_in, ref_clk_in};
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;

        // ======================================================
        // APB slave: zero wait states, answer in the access cycle
        // ======================================================
        next_st.pready  = psel_in && !penable_in;
        next_st.pslverr = 1'b0;
        if (psel_in && !penable_in) begin
            case (paddr_in)
                pll_cfg_pkg::ADDR_CFG_LO: next_st.prdata = st.cfg[31:0];
                pll_cfg_pkg::ADDR_CFG_HI: next_st.prdata = st.cfg[63:32];
                pll_cfg_pkg::ADDR_STATUS: next_st.prdata = {11'h000, post_total,
                                                            osc_off, st.osc_d.ratio[11:0]};
                default: begin
                    next_st.prdata  = 32'h0000_0000;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        if (psel_in && penable_in && st.pready && pwrite_in) begin
            case (paddr_in)
                pll_cfg_pkg::ADDR_CFG_LO: cfg_w[31:0]  = merge(st.cfg[31:0], pwdata_in, pstrb_in);
                pll_cfg_pkg::ADDR_CFG_HI: cfg_w[63:32] = merge(st.cfg[63:32], pwdata_in, pstrb_in);
                default: cfg_w = st.cfg;
            endcase
        end
        // Reserved bits are kept at zero whatever the host writes.
        next_st.cfg = cfg_w & ~pll_cfg_pkg::RSVD_MASK;

        // ======================================================
        // Dividers
        // ======================================================
        next_st.ref_d = step(st.ref_d, edge_seen[pll_cfg_pkg::PIN_REF],
                             {2'h0, st.cfg[pll_cfg_pkg::REF_LSB +: pll_cfg_pkg::REF_W]});
        next_st.pd_ref_tick = st.cfg[pll_cfg_pkg::DETECTOR_REF_SOURCE_BIT] ? edge_seen[pll_cfg_pkg::PIN_REF]
                                                              : next_st.ref_d.tick;
        next_st.p1_d = step(st.p1_d, edge_seen[pll_cfg_pkg::PIN_VCO],
                            pll_cfg_pkg::post_bin_ratio(st.cfg[pll_cfg_pkg::POST_STAGE_ONE_SEL_LSB +: 2]));
        next_st.p2_d = step(st.p2_d, next_st.p1_d.tick,
                            pll_cfg_pkg::post_odd_ratio(st.cfg[pll_cfg_pkg::POST_STAGE_TWO_SEL_LSB +: 2]));
        next_st.p3_d = step(st.p3_d, next_st.p2_d.tick,
                            pll_cfg_pkg::post_odd_ratio(st.cfg[pll_cfg_pkg::POST_STAGE_THREE_SEL_LSB +: 2]));
        case (fb_src)
            2'h0:    fb_ev = next_st.p3_d.tick;
            2'h2:    fb_ev = edge_seen[pll_cfg_pkg::PIN_VCO];
            default: fb_ev = edge_seen[pll_cfg_pkg::PIN_FBK];
        endcase
        // A in the low three bits and M above form one 14-bit modulus.
        next_st.fbk_d = step(st.fbk_d, fb_ev,
                             st.cfg[pll_cfg_pkg::FBK_LSB +: pll_cfg_pkg::FBK_W]);
        // With the oscillator or its loop powered down, edges are ignored and its counter is held at zero.
        next_st.osc_d = step(st.osc_d, edge_seen[pll_cfg_pkg::PIN_OSC] && !osc_off,
                             pll_cfg_pkg::osc_ratio(st.cfg[pll_cfg_pkg::OSC_SEL_LSB +: 3]));
        if (osc_off) begin
            next_st.osc_d.ratio = pll_cfg_pkg::osc_ratio(st.cfg[pll_cfg_pkg::OSC_SEL_LSB +: 3]);
            next_st.osc_d.cnt   = '0;
        end

        // ======================================================
        // Crystal loop controls
        // ======================================================
        next_st.fine_tune = st.cfg[pll_cfg_pkg::FINE_BIT];
        next_st.pol_inv   = st.cfg[pll_cfg_pkg::POL_BIT];
        next_st.loop_pd   = st.cfg[pll_cfg_pkg::LOOP_PD_BIT];
        next_st.osc_pd    = st.cfg[pll_cfg_pkg::OSC_SEL_LSB +: 3]
                            == pll_cfg_pkg::OSC_PWRDN_CODE;
        next_st.pump_sel  = 4'h1 << st.cfg[pll_cfg_pkg::PUMP_LSB +: 2];
        next_st.cap_code  = st.cfg[pll_cfg_pkg::CAP_LSB +: 4];
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st          <= '0;
            st.cfg      <= pll_cfg_pkg::CFG_RESET;
            // The pump select is one-hot from the first cycle, matching the reset code.
            st.pump_sel <= 4'h1 << pll_cfg_pkg::CFG_RESET[pll_cfg_pkg::PUMP_LSB +: 2];
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata_out                = st.prdata;
    assign pready_out                = st.pready;
    assign pslverr_out               = st.pslverr;
    assign ref_div_tick_out          = st.ref_d.tick;
    assign pd_ref_tick_out           = st.pd_ref_tick;
    assign post_tick_out             = st.p3_d.tick;
    assign fbk_tick_out              = st.fbk_d.tick;
    assign osc_tick_out              = st.osc_d.tick;
    assign fine_tune_enable_out      = st.fine_tune;
    assign tune_polarity_invert_out  = st.pol_inv;
    assign osc_loop_powerdown_out    = st.loop_pd;
    assign osc_powerdown_out         = st.osc_pd;
    assign osc_loop_pump_current_out = st.pump_sel;
    assign coarse_cap_code_out       = st.cap_code;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    ref_tick_cause_a: assert property (
        ref_div_tick_out |-> $past(edge_seen[pll_cfg_pkg::PIN_REF])
            && $past(st.ref_d.cnt) + 14'h0001 >= $past(st.ref_d.ratio))
        else $error("reference tick without a completed count");
    fbk_ratio_a: assert property (
        fbk_tick_out |-> $past(st.fbk_d.cnt) + 14'h0001 >= $past(st.fbk_d.ratio))
        else $error("feedback tick before its count");
    post_one_a: assert property (
        st.p1_d.ratio inside {14'h0000, 14'h0001, 14'h0002, 14'h0004, 14'h0008})
        else $error("post stage one ratio out of set");
    post_two_a: assert property (
        st.p2_d.ratio inside {14'h0000, 14'h0001, 14'h0003, 14'h0005, 14'h0004})
        else $error("post stage two ratio out of set");
    post_three_a: assert property (
        st.p3_d.ratio inside {14'h0000, 14'h0001, 14'h0003, 14'h0005, 14'h0004})
        else $error("post stage three ratio out of set");
    reserved_zero_a: assert property (
        st.cfg[23:22] == 2'h0)
        else $error("reserved configuration bits not zero");
    osc_down_a: assert property (
        $changed(st.cfg[51:49]) |=> osc_powerdown_out == (st.cfg[51:49] == 3'h7))
        else $error("oscillator power-down does not follow select");
    osc_frozen_a: assert property (
        osc_powerdown_out |-> !osc_tick_out)
        else $error("oscillator divider ticks while powered down");
    fine_tune_a: assert property (
        ##1 fine_tune_enable_out == $past(st.cfg[61]))
        else $error("fine tune enable does not follow its bit");
    polarity_a: assert property (
        ##1 tune_polarity_invert_out == $past(st.cfg[54]))
        else $error("polarity output does not follow its bit");
    loop_down_a: assert property (
        ##1 osc_loop_powerdown_out == $past(st.cfg[55]))
        else $error("loop power-down does not follow its bit");
    pump_sel_a: assert property (
        $onehot(osc_loop_pump_current_out))
        else $error("pump current select not one-hot");
    pd_ref_src_a: assert property (
        st.cfg[14] && $stable(st.cfg[14]) |=> pd_ref_tick_out == $past(edge_seen[0]))
        else $error("detector reference not from pin");
    cascade_a: assert property (
        post_tick_out |-> $past(edge_seen[pll_cfg_pkg::PIN_VCO])
            && $past(st.p1_d.cnt) + 14'h0001 >= $past(st.p1_d.ratio))
        else $error("post output without a VCO edge");
    ratio_at_wrap_a: assert property (
        $changed(st.ref_d.ratio) |-> ref_div_tick_out)
        else $error("reference ratio changed mid-period");

    // ==========================================================
    // Source selection, control levels and bus answer
    // ==========================================================
    // Each feedback tick is traced back to the event of the source that was
    // selected one cycle earlier, so a wrong source shows up on its first tick.
    fbk_post_src_a: assert property (
        fbk_tick_out && $past(fb_src) == 2'h0 |-> post_tick_out)
        else $error("feedback tick without a post divider tick");
    fbk_vco_src_a: assert property (
        fbk_tick_out && $past(fb_src) == 2'h2 |-> $past(edge_seen[pll_cfg_pkg::PIN_VCO]))
        else $error("feedback tick without a VCO edge");
    fbk_pin_src_a: assert property (
        fbk_tick_out && $past(fb_src[0]) |-> $past(edge_seen[pll_cfg_pkg::PIN_FBK]))
        else $error("feedback tick without a feedback pin edge");
    pd_ref_div_a: assert property (
        !st.cfg[pll_cfg_pkg::DETECTOR_REF_SOURCE_BIT] |=> pd_ref_tick_out == ref_div_tick_out)
        else $error("detector reference not from reference divider");
    coarse_cap_a: assert property (
        ##1 coarse_cap_code_out == $past(st.cfg[59:56]))
        else $error("coarse capacitance code does not follow its bits");
    pump_code_a: assert property (
        ##1 osc_loop_pump_current_out == (4'h1 << $past(st.cfg[53:52])))
        else $error("pump current select does not follow its code");
    osc_count_a: assert property (
        osc_tick_out |-> $past(edge_seen[pll_cfg_pkg::PIN_OSC])
            && $past(st.osc_d.cnt) + 14'h0001 >= $past(st.osc_d.ratio))
        else $error("oscillator tick without a completed count");
    fbk_wrap_a: assert property (
        $changed(st.fbk_d.ratio) |-> fbk_tick_out)
        else $error("feedback ratio changed mid-period");
    post_one_wrap_a: assert property (
        $changed(st.p1_d.ratio) |-> st.p1_d.tick)
        else $error("post stage one ratio changed mid-period");
    bus_ready_a: assert property (
        ##1 pready_out == $past(psel_in && !penable_in))
        else $error("bus answer not one cycle after setup");

endmodule
`default_nettype wire

// *** tb/apb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
    // Clock
    input  wire logic        clk_in,
    // APB master side
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic      [7:0]  paddr_out,
    output logic      [31:0] pwdata_out,
    output logic      [3:0]  pstrb_out,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    // ==========================================================
    // Bus cycle
    // ==========================================================
    initial begin
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 8'h00;
        pwdata_out  = 32'h0000_0000;
        pstrb_out   = 4'h0;
    end

    // Called just after a rising edge; the request is held until pready is seen high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic err);
        if (w && a == pll_cfg_pkg::ADDR_CFG_LO) begin
            d = d & ~pll_cfg_pkg::RSVD_MASK[31:0];
        end
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= w;
        paddr_out   <= a;
        pwdata_out  <= d;
        pstrb_out   <= s;
        @(posedge clk_in);
        penable_out <= 1'b1;
        // Only pready seen high or the bench's cycle ceiling ends this wait.
        do begin
            @(posedge clk_in);
        end while (pready_in !== 1'b1);
        rd = prdata_in;
        err = pslverr_in;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        pwdata_out  <= ~d;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ==========================================================
    // Signals and instances
    // ==========================================================
    localparam logic [7:0] LO = pll_cfg_pkg::ADDR_CFG_LO;
    localparam logic [7:0] HI = pll_cfg_pkg::ADDR_CFG_HI;
    localparam logic [7:0] ST = pll_cfg_pkg::ADDR_STATUS;
    typedef struct packed {logic [31:0] val; logic [31:0] msk; logic err_exp;} exp_t;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, fine, pol, lpd, opd;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0]  pstrb, pump, cap;
    logic [3:0]  pins = 4'h0;
    logic [4:0]  tk;
    exp_t        q[$];
    int          cnt[5] = '{0, 0, 0, 0, 0};
    int          base[5];
    int          miscompares = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          odd[4] = '{1, 3, 5, 4};
    int          oscr[8] = '{1, 3072, 3156, 2430, 2500, 4000, 3375, 0};
    int          p;

    always #5 clk_in = ~clk_in;

    apb_host_model host (.clk_in(clk_in), .psel_out(psel), .penable_out(penable),
        .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb),
        .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

    pll_divider_config i_pll_divider_config (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .ref_clk_in(pins[0]), .vco_clk_in(pins[1]),
        .fbk_pin_in(pins[2]), .osc_clk_in(pins[3]), .ref_div_tick_out(tk[0]),
        .pd_ref_tick_out(tk[1]), .post_tick_out(tk[2]), .fbk_tick_out(tk[3]),
        .osc_tick_out(tk[4]), .fine_tune_enable_out(fine), .tune_polarity_invert_out(pol),
        .osc_loop_powerdown_out(lpd), .osc_powerdown_out(opd),
        .osc_loop_pump_current_out(pump), .coarse_cap_code_out(cap));

    // ==========================================================
    // Checking and monitor
    // ==========================================================
    task automatic check(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            miscompares++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // The oldest note is taken off whenever a bus answer is seen.
    always @(posedge clk_in) begin
        exp_t x;
        cyc++;
        for (int k = 0; k < 5; k++) if (tk[k] === 1'b1) cnt[k]++;
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            x = q.pop_front();
            check((prdata & x.msk) === x.val && pslverr === x.err_exp, "bus answer");
        end
        if (cyc == 40000) begin
            check(0, "timeout");
            summarize();
        end
    end

    // ==========================================================
    // Stimulus tasks
    // ==========================================================
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] m, input logic [31:0] e,
                       input logic er);
        logic [31:0] rd;
        logic        err;
        q.push_back('{val: e, msk: m, err_exp: er});
        host.xfer(w, a, d, s, rd, err);
    endtask

    // Pins stay high and low two cycles each so the synchronisers see every edge.
    task automatic edges(input logic [3:0] mask, input int n);
        repeat (n) begin
            pins <= mask;
            repeat (2) @(posedge clk_in);
            pins <= 4'h0;
            repeat (2) @(posedge clk_in);
        end
        repeat (8) @(posedge clk_in);
    endtask

    // A fresh reset leaves every ratio at zero, so one priming edge loads the new ratios.
    task automatic setup(input logic [31:0] lo, input logic [31:0] hi, input logic [3:0] mask);
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        acc(1, LO, lo, 4'hF, 0, 0, 0);
        acc(1, HI, hi, 4'hF, 0, 0, 0);
        edges(mask, 1);
        base = cnt;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(32'h5A5E));
        setup(0, 0, 4'h0);
        check(tk === 5'h00 && {fine, pol, lpd, opd} === 4'h0 && pump === 4'h1, "reset state");
        acc(0, LO, 0, 4'hF, 32'hFFFF_FFFF, 0, 0);
        acc(0, 8'h0C, 0, 4'hF, 32'hFFFF_FFFF, 0, 1);
        acc(1, 8'h10, 32'hFFFF_FFFF, 4'hF, 0, 0, 1);
        rv = $urandom;
        acc(1, LO, rv, 4'hF, 0, 0, 0);
        acc(0, LO, 0, 4'hF, 32'hFFFF_FFFF, rv & 32'hFF3F_FFFF, 0);
        acc(1, LO, 32'hFFFF_FFFF, 4'h2, 0, 0, 0);
        acc(0, LO, 0, 4'hF, 32'hFFFF_FFFF, (rv & 32'hFF3F_FFFF) | 32'h0000_FF00, 0);
        for (int k = 0; k < 4; k++) begin
            acc(1, HI, (k[0] << 29) | (k[1] << 22) | ((k == 2) << 23) | (k << 20)
                | ((k * 5) << 24) | ((k == 3 ? 7 : k) << 17), 4'hF, 0, 0, 0);
            repeat (3) @(posedge clk_in);
            check(fine === k[0] && pol === k[1] && lpd === (k == 2), "loop levels");
            check(pump === (4'h1 << k) && cap === 4'(k * 5), "pump or cap");
            check(opd === (k == 3), "osc power-down");
        end
        setup(32'h0000_0005, 0, 4'h1);
        edges(4'h1, 14);
        check(cnt[0] - base[0] == 2 && cnt[1] - base[1] == 2, "ref divide");
        setup(32'h0000_4005, 0, 4'h1);
        edges(4'h1, 7);
        check(cnt[1] - base[1] == 7 && cnt[0] - base[0] == 1, "ref pin path");
        for (int c = 0; c < 4; c++) begin
            setup((c << 16) | (c << 18) | (c << 20), 0, 4'h2);
            p = (1 << c) * odd[c] * odd[c];
            acc(0, ST, 0, 4'hF, 32'h001F_E000, p << 13, 0);
            edges(4'h2, 2 * p - 1);
            check(cnt[2] - base[2] == 1 && cnt[3] - base[3] == 1, "post cascade");
        end
        for (int s = 1; s < 4; s++) begin
            setup(32'h0B00_0000, s << 6, (s == 2) ? 4'h2 : 4'h4);
            edges((s == 2) ? 4'h2 : 4'h4, 33);
            check(cnt[3] - base[3] == 3, "feedback divide");
        end
        setup(0, 1 << 17, 4'h8);
        edges(4'h8, 3071);
        check(cnt[4] - base[4] == 0, "osc early tick");
        edges(4'h8, 1);
        check(cnt[4] - base[4] == 1, "osc ratio");
        setup(0, 1 << 23, 4'h8);
        edges(4'h8, 4);
        check(cnt[4] - base[4] == 0, "loop down ticks");
        acc(0, ST, 0, 4'hF, 32'h0000_1000, 32'h0000_1000, 0);
        for (int c = 0; c < 8; c++) begin
            setup(0, c << 17, 4'h8);
            acc(0, ST, 0, 4'hF, (c == 7) ? 32'h1000 : 32'h1FFF,
                (c == 7) ? 32'h1000 : oscr[c], 0);
        end
        repeat (4) @(posedge clk_in);
        summarize();
    end
endmodule
`default_nettype wire
